/* File: logic/conv_accumulator.sv */
// Purpose: sums 2^N single conversions and returns their average
// Assumes: samples arrive as one-cycle strobes on the same clock
// Notes:   a start pulse discards any partial sum
`timescale 1ns/100ps
`default_nettype none
module conv_accumulator
  import light_regs_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // control
  input  wire logic              start,
  input  wire logic [2:0]        avg_code,
  // samples in
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample,
  // average out
  output logic                   mean_valid,
  output logic [DATA_W-1:0]      mean
);
  localparam int ACC_W = DATA_W + AVG_EXTRA_BITS;

  logic [ACC_W-1:0]          acc;
  logic [AVG_EXTRA_BITS-1:0] count;
  logic [2:0]                code;
  logic [ACC_W-1:0]          next_acc;
  logic                      last;

  assign next_acc = acc + {{AVG_EXTRA_BITS{1'b0}}, sample};
  // 2^N conversions per cycle, N latched at start
  assign last = (count == AVG_EXTRA_BITS'((1 << code) - 1));

  // sum and count; code held so a mid-run change cannot corrupt the divide
  always_ff @(posedge clk) begin
    if (srst || start) begin
      acc   <= '0;
      count <= '0;
      code  <= avg_code;
    end else if (sample_valid) begin
      acc   <= last ? '0 : next_acc;
      count <= last ? '0 : count + 1'b1;
    end
  end

  // divide by a power of two is a plain shift
  always_ff @(posedge clk) begin
    if (srst) begin
      mean_valid <= 1'b0;
      mean       <= '0;
    end else begin
      mean_valid <= sample_valid && last && !start;
      if (sample_valid && last && !start) begin
        mean <= DATA_W'(next_acc >> code);
      end
    end
  end
endmodule : conv_accumulator
`default_nettype wire

/* File: logic/light_param_and_result_regs.sv */
// Purpose: ambient parameter register, ambient and proximity result pairs
// Assumes: register port driven by the two-wire slave on CLK
// Notes:   front-end strobes are synchronous to CLK
// What this block does
// - continuous-conversion bit, writable, 1 enables, resets disabled
// - offset compensation enable bit, writable, resets to enabled
// - when enabled, measure offset first and subtract it from the reading
// - averaging code N gives 2^N conversions; result is their average
// - averaging field resets to 101, thirty-two conversions
// - parameter writes wait while self-timed runs, apply once it is switched off
// - ambient result is 16 bits, high byte at 85h, low at 86h
// - ambient result bytes are read-only; writes never change them
// - proximity result is 16 bits, high byte at 87h, low at 88h
// - proximity result bytes are read-only; low byte holds bits 7:0
// - parameter fields: bit7 cont, bits6:4 rate, bit3 offset, bits2:0 avg
`timescale 1ns/100ps
`default_nettype none
module light_param_and_result_regs
  import light_regs_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              SRST,
  // register port
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic [7:0]        REG_WDATA,
  output logic [7:0]             REG_RDATA,
  // mode from the measurement sequencer
  input  wire logic              SELF_TIMED,
  input  wire logic              MEAS_START,
  // ambient front end
  output logic                   OFFSET_REQ,
  input  wire logic              OFFSET_VALID,
  input  wire logic [DATA_W-1:0] OFFSET_DATA,
  output logic                   CONV_REQ,
  input  wire logic              CONV_VALID,
  input  wire logic [DATA_W-1:0] CONV_DATA,
  output logic                   ALS_DONE,
  // proximity front end
  input  wire logic              PROX_VALID,
  input  wire logic [DATA_W-1:0] PROX_DATA,
  // applied ambient settings
  output logic                   CONT_CONV,
  output logic [2:0]             ALS_RATE
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OFFS = 3'b010,
    ST_CONV = 3'b100
  } meas_e;

  meas_e             state;
  meas_e             next_state;
  logic [7:0]        param;
  logic [7:0]        applied;
  logic [DATA_W-1:0] offset;
  logic [DATA_W-1:0] ambient;
  logic [DATA_W-1:0] proximity;
  logic [DATA_W-1:0] corrected;
  logic              mean_valid;
  logic [DATA_W-1:0] mean;
  logic              start_run;
  logic              offset_en;

  // averaging field extraction shared by the accumulator hookup and the checks
  function automatic logic [2:0] avg_field(input logic [7:0] p);
    avg_field = p[POS_AVG_HI:POS_AVG_LO];
  endfunction : avg_field

  // software copy; reset value 0000_1101
  always_ff @(posedge CLK) begin
    if (SRST) begin
      param <= RST_AMBIENT_PARAMETER;
    end else if (REG_WR && REG_ADDR == ADDR_AMBIENT_PARAMETER) begin
      param <= REG_WDATA;
    end
  end

  // applied copy freezes while self-timed runs; re-latched once it is off
  always_ff @(posedge CLK) begin
    if (SRST) begin
      applied <= RST_AMBIENT_PARAMETER;
    end else if (!SELF_TIMED) begin
      applied <= param;
    end
  end

  assign CONT_CONV = applied[POS_CONT_CONV];
  assign ALS_RATE  = applied[POS_RATE_HI:POS_RATE_LO];
  assign offset_en = applied[POS_OFFSET_EN];

  // continuous conversion restarts right after each result
  assign start_run = (state == ST_IDLE) && (MEAS_START || (CONT_CONV && ALS_DONE));

  // measurement sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_run) next_state = offset_en ? ST_OFFS : ST_CONV;
      ST_OFFS: if (OFFSET_VALID) next_state = ST_CONV;
      ST_CONV: if (mean_valid) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign OFFSET_REQ = (state == ST_OFFS);
  assign CONV_REQ   = (state == ST_CONV);

  // offset held for the run; cleared so a disabled run subtracts nothing
  always_ff @(posedge CLK) begin
    if (SRST || (start_run && !offset_en)) begin
      offset <= '0;
    end else if (state == ST_OFFS && OFFSET_VALID) begin
      offset <= OFFSET_DATA;
    end
  end

  conv_accumulator #(
    .DATA_W (DATA_W)
  ) u_acc (
    .clk          (CLK),
    .srst         (SRST),
    .start        (start_run),
    .avg_code     (avg_field(applied)),
    .sample_valid (CONV_VALID && state == ST_CONV),
    .sample       (CONV_DATA),
    .mean_valid   (mean_valid),
    .mean         (mean)
  );

  // clamp at zero: an offset above the reading means darkness, not wrap
  assign corrected = (mean > offset) ? mean - offset : '0;

  // whole 16-bit word in one edge so a pair never mixes old and new
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ambient  <= RST_RESULT;
      ALS_DONE <= 1'b0;
    end else begin
      ALS_DONE <= mean_valid && state == ST_CONV;
      if (mean_valid && state == ST_CONV) begin
        ambient <= corrected;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      proximity <= RST_RESULT;
    end else if (PROX_VALID) begin
      proximity <= PROX_DATA;
    end
  end

  // registered read mux; unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else begin
      unique case (REG_ADDR)
        ADDR_AMBIENT_PARAMETER:   REG_RDATA <= param;
        ADDR_AMBIENT_RESULT_HIGH: REG_RDATA <= ambient[15:8];
        ADDR_AMBIENT_RESULT_LOW:  REG_RDATA <= ambient[7:0];
        ADDR_PROX_RESULT_HIGH:    REG_RDATA <= proximity[15:8];
        ADDR_PROX_RESULT_LOW:     REG_RDATA <= proximity[7:0];
        default:                  REG_RDATA <= 8'h00;
      endcase
    end
  end

  // checks
  sequence s_param_write;
    REG_WR && REG_ADDR == ADDR_AMBIENT_PARAMETER;
  endsequence

  sequence s_offset_taken;
    state == ST_OFFS && OFFSET_VALID;
  endsequence

  property p_reset_param;
    @(posedge CLK) SRST |=> (param == RST_AMBIENT_PARAMETER && CONT_CONV == RST_CONT_CONV
                             && ALS_RATE == RST_RATE);
  endproperty
  a_reset_param: assert property (p_reset_param)
    else $error("parameter register reset value wrong");

  property p_write_param;
    @(posedge CLK) disable iff (SRST) s_param_write |=> param == $past(REG_WDATA);
  endproperty
  a_write_param: assert property (p_write_param)
    else $error("parameter write not stored");

  property p_frozen;
    @(posedge CLK) disable iff (SRST) SELF_TIMED && $past(SELF_TIMED) |-> $stable(applied);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("applied settings changed during self-timed mode");

  property p_apply_off;
    @(posedge CLK) disable iff (SRST) !SELF_TIMED ##1 !SELF_TIMED |-> applied == $past(param);
  endproperty
  a_apply_off: assert property (p_apply_off)
    else $error("settings not applied while self-timed mode is off");

  property p_offset_first;
    @(posedge CLK) disable iff (SRST)
      state == ST_IDLE && start_run && offset_en |=> OFFSET_REQ && !CONV_REQ;
  endproperty
  a_offset_first: assert property (p_offset_first)
    else $error("conversion began before offset measurement");

  property p_offset_then_conv;
    @(posedge CLK) disable iff (SRST) s_offset_taken |=> CONV_REQ && offset == $past(OFFSET_DATA);
  endproperty
  a_offset_then_conv: assert property (p_offset_then_conv)
    else $error("offset not captured before conversions");

  property p_result_corrected;
    @(posedge CLK) disable iff (SRST)
      mean_valid && state == ST_CONV |=> ALS_DONE && ambient == $past(corrected);
  endproperty
  a_result_corrected: assert property (p_result_corrected)
    else $error("ambient result not offset corrected");

  property p_ambient_ro;
    @(posedge CLK) disable iff (SRST) !ALS_DONE |-> $stable(ambient);
  endproperty
  a_ambient_ro: assert property (p_ambient_ro)
    else $error("ambient result changed without a measurement");

  property p_prox_ro;
    @(posedge CLK) disable iff (SRST) !$past(PROX_VALID) |-> $stable(proximity);
  endproperty
  a_prox_ro: assert property (p_prox_ro)
    else $error("proximity result changed without a measurement");

  property p_read_amb_high;
    @(posedge CLK) disable iff (SRST)
      REG_ADDR == ADDR_AMBIENT_RESULT_HIGH |=> REG_RDATA == $past(ambient[15:8]);
  endproperty
  a_read_amb_high: assert property (p_read_amb_high)
    else $error("ambient high byte read wrong");

  property p_read_prox_low;
    @(posedge CLK) disable iff (SRST)
      REG_ADDR == ADDR_PROX_RESULT_LOW |=> REG_RDATA == $past(proximity[7:0]);
  endproperty
  a_read_prox_low: assert property (p_read_prox_low)
    else $error("proximity low byte read wrong");

  property p_single_conv;
    @(posedge CLK) disable iff (SRST)
      start_run && !offset_en && avg_field(applied) == 3'h0 ##1 CONV_VALID
      |=> mean_valid;
  endproperty
  a_single_conv: assert property (p_single_conv)
    else $error("averaging of one conversion did not finish");

  property p_pair_atomic;
    @(posedge CLK) disable iff (SRST)
      $changed(ambient[15:8]) |-> ALS_DONE;
  endproperty
  a_pair_atomic: assert property (p_pair_atomic)
    else $error("ambient high byte changed outside a result update");
endmodule : light_param_and_result_regs
`default_nettype wire

/* File: logic/light_regs_pkg.sv */
// Purpose: shared constants of the light parameter and result registers
// Assumes: byte-wide register port, addresses as seen by the two-wire slave
// Notes:   field positions refer to the ambient parameter register
package light_regs_pkg;
  localparam logic [7:0] ADDR_AMBIENT_PARAMETER   = 8'h84;
  localparam logic [7:0] ADDR_AMBIENT_RESULT_HIGH = 8'h85;
  localparam logic [7:0] ADDR_AMBIENT_RESULT_LOW  = 8'h86;
  localparam logic [7:0] ADDR_PROX_RESULT_HIGH    = 8'h87;
  localparam logic [7:0] ADDR_PROX_RESULT_LOW     = 8'h88;
  localparam int         POS_CONT_CONV            = 7;
  localparam int         POS_RATE_HI              = 6;
  localparam int         POS_RATE_LO              = 4;
  localparam int         POS_OFFSET_EN            = 3;
  localparam int         POS_AVG_HI               = 2;
  localparam int         POS_AVG_LO               = 0;
  localparam logic       RST_CONT_CONV            = 1'b0;
  localparam logic [2:0] RST_RATE                 = 3'h0;
  localparam logic       RST_OFFSET_EN            = 1'b1;
  localparam logic [2:0] RST_AVG                  = 3'h5;
  localparam logic [7:0] RST_AMBIENT_PARAMETER    = {RST_CONT_CONV, RST_RATE,
                                                     RST_OFFSET_EN, RST_AVG};
  localparam logic [15:0] RST_RESULT              = 16'h0000;
  localparam int         AVG_EXTRA_BITS           = 7;
endpackage : light_regs_pkg

/* File: verification/light_frontend_model.sv */
// Purpose: behavioural ambient front end answering offset and conversion requests
// Assumes: strobes launched on the falling edge, sampled by the block on the rising one
// Notes:   conversions alternate val and val+2, so averages of two or more give val+1
`timescale 1ns/100ps
`default_nettype none
module light_frontend_model #(
  parameter int DATA_W = 16
) (
  // clock
  input  wire logic              clk,
  // requests from the block
  input  wire logic              offset_req,
  input  wire logic              conv_req,
  // behaviour set by the bench
  input  wire logic [2:0]        avg_n,
  input  wire logic [7:0]        lag,
  input  wire logic [DATA_W-1:0] off_val,
  input  wire logic [DATA_W-1:0] conv_val,
  // strobes and data back
  output logic                   offset_valid,
  output logic                   conv_valid,
  output logic [DATA_W-1:0]      offset_data,
  output logic [DATA_W-1:0]      conv_data
);
  int   wait_cnt = 0;
  int   sent     = 0;
  logic off_done = 1'b0;

  initial begin
    offset_valid = 1'b0;
    conv_valid   = 1'b0;
    offset_data  = '0;
    conv_data    = '0;
  end

  // data toggles outside strobes so a stale value never looks valid
  always @(negedge clk) begin
    offset_valid <= 1'b0;
    conv_valid   <= 1'b0;
    offset_data  <= ~offset_data;
    conv_data    <= ~conv_data;
    if (!offset_req) off_done <= 1'b0;
    if (!conv_req) sent <= 0;
    if (!offset_req && !conv_req) wait_cnt <= 0;
    else if (wait_cnt < int'(lag)) wait_cnt <= wait_cnt + 1;
    else if (offset_req && !off_done) begin
      offset_valid <= 1'b1;
      offset_data  <= off_val;
      off_done     <= 1'b1;
      wait_cnt     <= 0;
    end else if (conv_req && sent < (1 << avg_n)) begin
      conv_valid <= 1'b1;
      conv_data  <= conv_val + DATA_W'(2 * (sent % 2));
      sent       <= sent + 1;
      wait_cnt   <= 0;
    end
  end
endmodule : light_frontend_model
`default_nettype wire

/* File: verification/light_param_and_result_regs_tb.sv */
// Purpose: self-checking bench for the parameter and result registers
// Assumes: bench drives on the falling edge, read data registered one cycle
// Notes:   front end is the behavioural model, proximity strobes come from here
`timescale 1ns/100ps
`default_nettype none
module light_param_and_result_regs_tb;
  import light_regs_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, self_timed = 1'b0;
  logic        meas_start = 1'b0, prox_valid = 1'b0;
  logic        offset_req, offset_valid, conv_req, conv_valid, als_done, cont_conv;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, lag = 8'h00, reg_rdata;
  logic [15:0] prox_data = 16'h0000, off_val = 16'h0000, conv_val = 16'h4321;
  logic [15:0] offset_data, conv_data;
  logic [2:0]  als_rate, avg_n = 3'h0;
  int          failures = 0, comparisons = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  light_param_and_result_regs dut (.CLK(clk), .SRST(srst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .SELF_TIMED(self_timed), .MEAS_START(meas_start), .OFFSET_REQ(offset_req),
    .OFFSET_VALID(offset_valid), .OFFSET_DATA(offset_data), .CONV_REQ(conv_req),
    .CONV_VALID(conv_valid), .CONV_DATA(conv_data), .ALS_DONE(als_done),
    .PROX_VALID(prox_valid), .PROX_DATA(prox_data), .CONT_CONV(cont_conv),
    .ALS_RATE(als_rate));

  light_frontend_model fe (.clk(clk), .offset_req(offset_req), .conv_req(conv_req),
    .avg_n(avg_n), .lag(lag), .off_val(off_val), .conv_val(conv_val),
    .offset_valid(offset_valid), .conv_valid(conv_valid),
    .offset_data(offset_data), .conv_data(conv_data));

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // address held one cycle, data read at the following falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    check_val({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  // bounded wait so a missing done pulse cannot hang the run
  task automatic wait_done;
    int i;
    for (i = 0; i < 3000 && als_done !== 1'b1; i++) @(negedge clk);
    check_val({15'h0000, als_done}, 16'h0001);
    @(negedge clk);
  endtask : wait_done

  task automatic run_meas(input logic [7:0] param, input logic [15:0] exp);
    wr(ADDR_AMBIENT_PARAMETER, param);
    avg_n = param[2:0];
    @(negedge clk);
    meas_start = 1'b1;
    @(negedge clk);
    meas_start = 1'b0;
    wait_done();
    rd(ADDR_AMBIENT_RESULT_HIGH, exp[15:8]);
    rd(ADDR_AMBIENT_RESULT_LOW, exp[7:0]);
  endtask : run_meas

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // watchdog at 20000 cycles, well beyond the several hundred cycles the tests need
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rd(ADDR_AMBIENT_PARAMETER, 8'h0d);
    for (int a = 8'h85; a <= 8'h88; a++) rd(a[7:0], 8'h00);
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00);
    wr(ADDR_AMBIENT_PARAMETER, 8'hb2);
    rd(ADDR_AMBIENT_PARAMETER, 8'hb2);
    check_val({15'h0000, cont_conv}, 16'h0001);
    check_val({13'h0000, als_rate}, 16'h0003);
    wr(ADDR_AMBIENT_PARAMETER, 8'h00);
    @(negedge clk);
    check_val({15'h0000, cont_conv}, 16'h0000);
    // applied copy must stay frozen while self-timed runs
    self_timed = 1'b1;
    wr(ADDR_AMBIENT_PARAMETER, 8'h70);
    repeat (2) @(negedge clk);
    check_val({13'h0000, als_rate}, 16'h0000);
    rd(ADDR_AMBIENT_PARAMETER, 8'h70);
    self_timed = 1'b0;
    repeat (2) @(negedge clk);
    check_val({13'h0000, als_rate}, 16'h0007);
    // every averaging code, offset off, strobes back to back right after the request
    for (int n = 0; n < 8; n++)
      run_meas({5'h00, n[2:0]}, (n == 0) ? conv_val : conv_val + 16'h0001);
    lag     = 8'h03;
    off_val = 16'h0321;
    run_meas(8'h09, 16'h4001);
    off_val = 16'hffff;
    run_meas(8'h08, 16'h0000);
    for (int a = 8'h85; a <= 8'h88; a++) wr(a[7:0], 8'hff);
    rd(ADDR_AMBIENT_RESULT_HIGH, 8'h00);
    rd(ADDR_AMBIENT_RESULT_LOW, 8'h00);
    rd(ADDR_PROX_RESULT_LOW, 8'h00);
    @(negedge clk);
    prox_data  = 16'ha55a;
    prox_valid = 1'b1;
    @(negedge clk);
    prox_valid = 1'b0;
    rd(ADDR_PROX_RESULT_HIGH, 8'ha5);
    rd(ADDR_PROX_RESULT_LOW, 8'h5a);
    // continuous mode only with self-timed off, second result needs no start
    off_val  = 16'h0000;
    conv_val = 16'h0777;
    run_meas(8'h80, 16'h0777);
    wait_done();
    wr(ADDR_AMBIENT_PARAMETER, 8'h00);
    repeat (40) @(negedge clk);
    // second reset after the runs have ended: settings and results must return to reset values
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd(ADDR_AMBIENT_PARAMETER, RST_AMBIENT_PARAMETER);
    rd(ADDR_AMBIENT_RESULT_LOW, 8'h00);
    rd(ADDR_PROX_RESULT_HIGH, 8'h00);
    check_val({15'h0000, cont_conv}, 16'h0000);
    wrap_up();
  end
endmodule : light_param_and_result_regs_tb
`default_nettype wire
